/* fcs_sequencer.sv */
// Host controller that drives a byte-wide parallel NOR flash through its
// pins, one user request at a time. Assumes all inputs synchronous to mclk
// and analog drivers that turn hv_a9 / hv_rst into the elevated pin level.
// Operation
// - Elevated reset level unprotects sectors temporarily
// - Elevated A9 read gives maker/part code
// - Write only ce low, we low, oe high
// - Single F0 write returns to read
// - Identify: AA, 55, 90 then read
// - Third verify cycle A21 picks half
// - Program AA,55,A0,location; bypass AA,55,20
// - Erase six writes, 10 chip, 30 sector
// - Bypass accepts only A0 program, 90/00 exit
`timescale 1ns/1ps

module fcs_sequencer
   import fcs_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               srst,
   input  wire fcs_pkg::fcs_cmd_type cmd,
   input  wire logic               cmd_valid,
   output logic                    cmd_ready,
   output fcs_pkg::fcs_rsp_type    rsp,
   output logic                    rsp_valid,
   input  wire logic               temp_unprotect,
   input  wire logic               supply_low,
   input  wire logic               flash_ready,
   input  wire logic [7:0]         dq_i,
   output fcs_pkg::fcs_pins_type   pins,
   output logic                    in_bypass,
   output fcs_pkg::fcs_erase_type  erase_state
);
   import fcs_pkg::*;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_STROBE = 3'b010,
      ST_RECOVER = 3'b011, ST_READ = 3'b100, ST_RSTP = 3'b101,
      ST_DONE = 3'b110
   } fcs_state_type;

   fcs_state_type st_reg, st_next;       // Sequencer state
   logic [4:0]    cnt_reg, cnt_next;     // Phase down-counter
   logic [2:0]    step_reg, step_next;   // Cycle index in sequence
   fcs_cmd_type   cmd_reg, cmd_next;     // Request being served
   fcs_pins_type  pins_reg, pins_next;   // Flash pin drive
   logic          byp_reg, byp_next;     // Device in unlock bypass
   fcs_erase_type er_reg, er_next;       // Erase progress
   fcs_rsp_type   rsp_reg, rsp_next;     // Answer word
   logic          rv_reg, rv_next;       // Answer strobe
   logic          rdy_reg, rdy_next;     // Last ready level
   fcs_cycle_type cyc;                   // Current cycle content

   // Number of bus cycles for an operation
   function automatic logic [2:0] seq_len(input fcs_op_type op);
      unique case (op)
         OP_ID_READ, OP_PROT_VERIFY:        seq_len = 3'd5;
         OP_PROGRAM:                        seq_len = 3'd4;
         OP_BYPASS_ENTER:                   seq_len = 3'd3;
         OP_BYPASS_PROG, OP_BYPASS_EXIT:    seq_len = 3'd2;
         OP_CHIP_ERASE, OP_SECTOR_ERASE:    seq_len = 3'd6;
         default:                           seq_len = 3'd1;
      endcase
   endfunction

   // Address and data of one cycle of a sequence
   function automatic fcs_cycle_type seq_cycle(input fcs_cmd_type c,
                                              input logic [2:0] s);
      fcs_cycle_type y;
      // unlock and command cycles at address zero, except verify's 90 (A21 kept) and sector erase's 30 (sector address)
      y = '0;
      unique case (c.op)
         OP_READ: begin
            y.rd = 1'b1;
            y.addr = c.addr;
         end
         // maker or part code, A6 and A1 low
         OP_HW_ID: begin
            y.rd = 1'b1;
            y.addr = {21'h000000, c.addr[0]};
         end
         OP_HW_VERIFY: begin
            y.rd = 1'b1;
            y.addr = {c.addr[SECT_MSB:SECT_LSB], PROT_OFS};
         end
         OP_ID_READ, OP_PROT_VERIFY: begin
            unique case (s)
               3'd0: y.data = CODE_UNLOCK1;
               3'd1: y.data = CODE_UNLOCK2;
               3'd2: begin
                  y.data = CODE_IDENT;
                  if (c.op == OP_PROT_VERIFY) begin
                     y.addr[HALF_BIT] = c.addr[HALF_BIT];
                  end
               end
               3'd3: begin
                  y.rd = 1'b1;
                  y.addr = (c.op == OP_PROT_VERIFY) ?
                     {c.addr[SECT_MSB:SECT_LSB], PROT_OFS} : c.addr;
               end
               default: y.data = CODE_RESET;
            endcase
         end
         OP_PROGRAM, OP_BYPASS_ENTER, OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
            unique case (s)
               3'd0, 3'd3: y.data = CODE_UNLOCK1;
               3'd1, 3'd4: y.data = CODE_UNLOCK2;
               3'd2: y.data = (c.op == OP_PROGRAM) ? CODE_PROG :
                  (c.op == OP_BYPASS_ENTER) ? CODE_BYPASS : CODE_ERASE;
               default: y.data = (c.op == OP_CHIP_ERASE) ? CODE_CHIP :
                  CODE_SECTOR;
            endcase
            if (c.op == OP_PROGRAM && s == 3'd3) begin
               y.addr = c.addr;
               y.data = c.data;
            end
            if (c.op == OP_SECTOR_ERASE && s == 3'd5) begin
               y.addr = {c.addr[SECT_MSB:SECT_LSB], 16'h0000};
            end
         end
         OP_BYPASS_PROG: begin
            y.addr = (s == 3'd0) ? '0 : c.addr;
            y.data = (s == 3'd0) ? CODE_PROG : c.data;
         end
         OP_BYPASS_EXIT: y.data = (s == 3'd0) ? CODE_IDENT : CODE_BYP_END;
         OP_SUSPEND:     y.data = CODE_SUSPEND;
         OP_RESUME:      y.data = CODE_RESUME;
         default:        y.data = CODE_RESET;
      endcase
      seq_cycle = y;
   endfunction

   // Whether a request suits the device's present mode
   // never send broken sequences
   function automatic logic cmd_legal(input fcs_op_type op, input logic b,
                                      input fcs_erase_type e);
      logic ok;
      ok = (op != OP_NONE);
      // bypass allows only its own pair, reads and hardware reset
      if (b) begin
         ok = op inside {OP_BYPASS_PROG, OP_BYPASS_EXIT, OP_READ,
                         OP_HW_RESET};
      end else if (op inside {OP_BYPASS_PROG, OP_BYPASS_EXIT}) begin
         ok = 1'b0;
      end
      if (op == OP_SUSPEND && e != ER_ERASING) begin
         ok = 1'b0;
      end
      if (op == OP_RESUME && e != ER_SUSPENDED) begin
         ok = 1'b0;
      end
      // no new erase or bypass while suspended
      if (e == ER_SUSPENDED && op inside {OP_CHIP_ERASE, OP_SECTOR_ERASE,
                                          OP_BYPASS_ENTER}) begin
         ok = 1'b0;
      end
      cmd_legal = ok;
   endfunction

   // Pins at the start of a cycle: address and data set, ce low, oe and we idle
   function automatic fcs_pins_type setup_pins(input fcs_pins_type p,
                                              input fcs_cycle_type y,
                                              input fcs_op_type op);
      fcs_pins_type q;
      q = p;
      q.ce_n  = 1'b0;
      q.oe_n  = 1'b1;
      q.we_n  = 1'b1;
      q.addr  = y.addr;
      q.dq_o  = y.data;
      q.dq_oe = ~y.rd;
      q.hv_a9 = op inside {OP_HW_ID, OP_HW_VERIFY};
      setup_pins = q;
   endfunction

   // hold requests while supply low, and all but suspend and hardware reset while the flash is busy
   assign cmd_ready = (st_reg == ST_IDLE) && !supply_low &&
                      (flash_ready || cmd.op inside {OP_SUSPEND, OP_HW_RESET});
   assign pins        = pins_reg;
   assign rsp         = rsp_reg;
   assign rsp_valid   = rv_reg;
   assign in_bypass   = byp_reg;
   assign erase_state = er_reg;
   assign cyc         = seq_cycle(cmd_reg, step_reg);

   // Next-state logic of the sequencer
   always_comb begin
      st_next   = st_reg;
      cnt_next  = cnt_reg;
      step_next = step_reg;
      cmd_next  = cmd_reg;
      pins_next = pins_reg;
      byp_next  = byp_reg;
      er_next   = er_reg;
      rsp_next  = rsp_reg;
      rv_next   = 1'b0;
      rdy_next  = flash_ready;
      // flash leaves reset with the sequencer
      if (st_reg != ST_RSTP) begin
         pins_next.rst_n = 1'b1;
      end
      // Erase finished when ready rises
      if (er_reg == ER_ERASING && flash_ready && !rdy_reg) begin
         er_next = ER_NONE;
      end
      unique case (st_reg)
         // Wait for a request
         ST_IDLE: begin
            if (cmd_valid && cmd_ready) begin
               cmd_next  = cmd;
               step_next = 3'd0;
               rsp_next  = '0;
               if (!cmd_legal(cmd.op, byp_reg, er_reg)) begin
                  rsp_next.err = 1'b1;
                  st_next = ST_DONE;
               end else if (cmd.op == OP_HW_RESET) begin
                  st_next = ST_RSTP;
                  cnt_next = RP_CYC - 5'h01;
                  pins_next.rst_n = 1'b0;
               end else begin
                  st_next = ST_SETUP;
                  cnt_next = SETUP_CYC - 5'h01;
                  pins_next = setup_pins(pins_reg, seq_cycle(cmd, 3'd0),
                                         cmd.op);
               end
            end
         end
         // Address settles before the strobe falls
         ST_SETUP: begin
            if (cnt_reg != 5'h00) begin
               cnt_next = cnt_reg - 5'h01;
            end else if (cyc.rd) begin
               st_next = ST_READ;
               pins_next.oe_n = 1'b0;
               cnt_next = ACC_CYC - 5'h01;
            end else begin
               st_next = ST_STROBE;
               pins_next.we_n = 1'b0;
               cnt_next = WP_CYC - 5'h01;
            end
         end
         // strobe held for the full pulse width
         ST_STROBE: begin
            if (cnt_reg != 5'h00) begin
               cnt_next = cnt_reg - 5'h01;
            end else begin
               st_next = ST_RECOVER;
               pins_next.we_n = 1'b1;
               pins_next.ce_n = 1'b1;
               cnt_next = WPH_CYC - 5'h01;
            end
         end
         // Output enable low until access time passes, then sample
         ST_READ: begin
            if (cnt_reg != 5'h00) begin
               cnt_next = cnt_reg - 5'h01;
            end else begin
               rsp_next.data = dq_i;
               pins_next.oe_n = 1'b1;
               pins_next.ce_n = 1'b1;
               st_next = ST_RECOVER;
               cnt_next = WPH_CYC - 5'h01;
            end
         end
         // data held past the rising strobe
         ST_RECOVER: begin
            if (cnt_reg != 5'h00) begin
               cnt_next = cnt_reg - 5'h01;
            end else if (step_reg == seq_len(cmd_reg.op) - 3'd1) begin
               pins_next.dq_oe = 1'b0;
               pins_next.hv_a9 = 1'b0;
               st_next = ST_DONE;
            end else begin
               step_next = step_reg + 3'd1;
               st_next = ST_SETUP;
               cnt_next = SETUP_CYC - 5'h01;
               pins_next = setup_pins(pins_reg,
                  seq_cycle(cmd_reg, step_reg + 3'd1), cmd_reg.op);
            end
         end
         // Hardware reset pulse clears every mode
         ST_RSTP: begin
            if (cnt_reg != 5'h00) begin
               cnt_next = cnt_reg - 5'h01;
            end else begin
               pins_next.rst_n = 1'b1;
               byp_next = 1'b0;
               er_next = ER_NONE;
               st_next = ST_DONE;
            end
         end
         // Answer and update the tracked device mode
         ST_DONE: begin
            rv_next = 1'b1;
            st_next = ST_IDLE;
            if (!rsp_reg.err) begin
               unique case (cmd_reg.op)
                  OP_BYPASS_ENTER: byp_next = 1'b1;
                  OP_BYPASS_EXIT:  byp_next = 1'b0;
                  OP_SECTOR_ERASE: er_next = ER_ERASING;
                  // Erase may have ended while the suspend went out
                  OP_SUSPEND:      er_next = (er_next == ER_ERASING) ?
                                             ER_SUSPENDED : er_next;
                  OP_RESUME:       er_next = ER_ERASING;
                  default:         er_next = er_next;
               endcase
            end
         end
         default: st_next = ST_IDLE;
      endcase
      // elevated reset level follows the request, drops at once
      pins_next.hv_rst = temp_unprotect && pins_next.rst_n;
   end

   // Registers of the sequencer
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_reg   <= ST_IDLE;
         cnt_reg  <= 5'h00;
         step_reg <= 3'd0;
         cmd_reg  <= '{op: OP_NONE, addr: '0, data: '0};
         pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0,
                       hv_a9: 1'b0, hv_rst: 1'b0, addr: '0, dq_o: '0,
                       dq_oe: 1'b0};
         byp_reg  <= 1'b0;
         er_reg   <= ER_NONE;
         rsp_reg  <= '0;
         rv_reg   <= 1'b0;
         rdy_reg  <= 1'b0;
      end else begin
         st_reg   <= st_next;
         cnt_reg  <= cnt_next;
         step_reg <= step_next;
         cmd_reg  <= cmd_next;
         pins_reg <= pins_next;
         byp_reg  <= byp_next;
         er_reg   <= er_next;
         rsp_reg  <= rsp_next;
         rv_reg   <= rv_next;
         rdy_reg  <= rdy_next;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   sequence s_strobe;
      !pins_reg.we_n [*2] ##1 pins_reg.we_n;
   endsequence

   a_write_gate: assert property (
      !pins_reg.we_n |-> !pins_reg.ce_n && pins_reg.oe_n)
      else $error("write strobe without ce low and oe high");
   a_strobe_width: assert property (
      $fell(pins_reg.we_n) |-> s_strobe)
      else $error("write strobe width wrong");
   a_addr_stable: assert property (
      !pins_reg.we_n |-> $stable(pins_reg.addr))
      else $error("address moved during strobe");
   a_data_hold: assert property (
      $rose(pins_reg.we_n) |-> pins_reg.dq_oe && $stable(pins_reg.dq_o))
      else $error("data not held at strobe rise");
   a_no_contend: assert property (
      !pins_reg.oe_n |-> !pins_reg.dq_oe && pins_reg.we_n)
      else $error("data driven while flash outputs");
   a_unprotect_on: assert property (
      temp_unprotect ##1 pins_reg.rst_n |-> pins_reg.hv_rst)
      else $error("elevated reset level missing");
   a_protect_back: assert property (
      !temp_unprotect |=> !pins_reg.hv_rst)
      else $error("elevated reset level not removed");
   a_hw_id_pins: assert property (
      pins_reg.hv_a9 && !pins_reg.oe_n |-> !pins_reg.addr[6] &&
      (pins_reg.addr[1] == (cmd_reg.op == OP_HW_VERIFY)))
      else $error("bad pins for high-voltage read");
   a_program_code: assert property (
      !pins_reg.we_n && step_reg == 3'd2 && cmd_reg.op == OP_PROGRAM
      |-> pins_reg.dq_o == CODE_PROG)
      else $error("program set-up code wrong");
   a_erase_last: assert property (
      !pins_reg.we_n && step_reg == 3'd5 && cmd_reg.op == OP_SECTOR_ERASE
      |-> pins_reg.dq_o == CODE_SECTOR && pins_reg.addr[15:0] == 16'h0000)
      else $error("sector erase cycle wrong");
   a_suspend_legal: assert property (
      st_reg == ST_SETUP && cmd_reg.op == OP_SUSPEND |-> er_reg == ER_ERASING)
      else $error("suspend issued outside sector erase");
   a_bypass_only: assert property (
      byp_reg && st_reg == ST_SETUP |-> cmd_reg.op inside
      {OP_BYPASS_PROG, OP_BYPASS_EXIT, OP_READ})
      else $error("illegal command in bypass mode");
   a_read_answer: assert property (
      cmd_valid && cmd_ready && cmd.op == OP_READ && !byp_reg
      |-> ##[2:12] rv_reg)
      else $error("read answer late");

endmodule // fcs_sequencer

/* fcs_pkg.sv */
// Constants, bus-cycle timing and carrier types for the flash command
// sequencer. Assumes a 40 MHz mclk; all times are converted to cycles here.
package fcs_pkg;

   // Bus widths
   localparam int ADDR_W = 22;
   localparam int DATA_W = 8;

   // Address fields
   localparam int SECT_MSB = 21;
   localparam int SECT_LSB = 16;
   localparam int HALF_BIT = 21;
   localparam logic [15:0] PROT_OFS = 16'h0002;

   // Command data codes
   localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
   localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
   localparam logic [7:0] CODE_IDENT   = 8'h90;
   localparam logic [7:0] CODE_RESET   = 8'hf0;
   localparam logic [7:0] CODE_PROG    = 8'ha0;
   localparam logic [7:0] CODE_BYPASS  = 8'h20;
   localparam logic [7:0] CODE_ERASE   = 8'h80;
   localparam logic [7:0] CODE_CHIP    = 8'h10;
   localparam logic [7:0] CODE_SECTOR  = 8'h30;
   localparam logic [7:0] CODE_SUSPEND = 8'hb0;
   localparam logic [7:0] CODE_RESUME  = 8'h30;
   localparam logic [7:0] CODE_BYP_END = 8'h00;

   // Timing in ns and derived cycle counts (least times round up)
   localparam int CLK_NS    = 25;
   localparam int T_SETUP_NS = 25;
   localparam int T_WP_NS   = 35;
   localparam int T_WPH_NS  = 30;
   localparam int T_ACC_NS  = 100;
   localparam int T_RP_NS   = 500;
   localparam logic [4:0] SETUP_CYC = 5'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] WP_CYC    = 5'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] WPH_CYC   = 5'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] ACC_CYC   = 5'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] RP_CYC    = 5'((T_RP_NS + CLK_NS - 1) / CLK_NS);

   // Host operations
   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_RESET = 4'h1, OP_ID_READ = 4'h2,
      OP_PROT_VERIFY = 4'h3, OP_PROGRAM = 4'h4, OP_BYPASS_ENTER = 4'h5,
      OP_BYPASS_PROG = 4'h6, OP_BYPASS_EXIT = 4'h7, OP_CHIP_ERASE = 4'h8,
      OP_SECTOR_ERASE = 4'h9, OP_SUSPEND = 4'ha, OP_RESUME = 4'hb,
      OP_HW_ID = 4'hc, OP_HW_VERIFY = 4'hd, OP_HW_RESET = 4'he,
      OP_NONE = 4'hf
   } fcs_op_type;

   // Erase tracking
   typedef enum logic [1:0] {
      ER_NONE = 2'b00, ER_ERASING = 2'b01, ER_SUSPENDED = 2'b10
   } fcs_erase_type;

   // Request from the user side
   typedef struct packed {
      fcs_op_type        op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fcs_cmd_type;

   // Answer to the user side
   typedef struct packed {
      logic              err;
      logic [DATA_W-1:0] data;
   } fcs_rsp_type;

   // One bus cycle of a sequence
   typedef struct packed {
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fcs_cycle_type;

   // Flash pin outputs
   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              rst_n;
      logic              hv_a9;
      logic              hv_rst;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_o;
      logic              dq_oe;
   } fcs_pins_type;

endpackage

/* fcs_flash_model.sv */
// Behavioural byte-wide NOR flash seen from its pins.
// Assumes the sequencer's registered pins; mclk only paces busy time.
`timescale 1ns/1ps

module fcs_flash_model
   import fcs_pkg::*;
#(
   parameter logic [7:0] MAKER = 8'h3c, // Arbitrary maker code
   parameter logic [7:0] PART  = 8'h5e, // Arbitrary part code
   parameter logic [5:0] PROT  = 6'h05  // The one protected sector
)(
   input  wire logic             mclk,
   input  wire fcs_pins_type     pins,
   output logic [7:0]            dq_i,
   output logic                  flash_ready
);
   import fcs_pkg::*;
   int         st = 0;              // Command state, 0 = array read
   int         busy = 0;            // Cycles left of embedded work
   int         nwr = 0;             // Accepted write cycles
   logic       byp = 0, ers = 0, sus = 0;
   logic [7:0] mem [32];            // Small array slice
   logic [7:0] last = 8'h00;        // Last byte put on the bus
   logic [21:0] al;                 // Latched write address
   logic [7:0] d;
   // write only ce low, we low, oe high
   wire wr = !pins.ce_n && !pins.we_n && pins.oe_n;
   wire rd = !pins.ce_n && !pins.oe_n;
   wire pr = pins.addr[21:16] == PROT;
   wire [7:0] val = (pins.hv_a9 || st == 3) ?
      (pins.addr[1] ? {7'h0, pr} : (pins.addr[0] ? PART : MAKER)) :
      mem[{pins.addr[16], pins.addr[3:0]}];
   // Released bus shows the inverse of the last byte
   assign dq_i = rd ? val : ~last;
   assign flash_ready = (busy == 0);
   initial begin
      for (int i = 0; i < 32; i++) mem[i] = 8'hff;
   end
   always @(posedge pins.oe_n) last = val;
   // Busy time runs down off the sampling edge; erase ends with it
   always @(negedge mclk) begin
      if (busy > 0) begin
         busy = busy - 1;
         if (busy == 0) ers = 0;
      end
   end
   always @(negedge pins.rst_n) begin
      st = 0; byp = 0; busy = 0; ers = 0; sus = 0;
   end
   // address at later fall of the strobes
   always @(posedge wr) al = pins.addr;
   always @(negedge wr) begin
      d = pins.dq_o;
      nwr++;
      if (ers && d == 8'hb0) begin
         ers = 0; sus = 1; busy = 8;
      end else if (busy != 0) begin
      end else if (byp) begin
         if (st == 4) begin
            mem[{al[16], al[3:0]}] &= d; st = 0; busy = 6;
         end else if (st == 8) begin
            byp = (d != 8'h00); st = 0;
         end else st = (d == 8'ha0) ? 4 : (d == 8'h90) ? 8 : 0;
      end else if (d == 8'hf0) st = 0;
      else case (st)
         0, 3: if (d == 8'haa) st = 1;
            else if (sus && d == 8'h30) begin
               sus = 0; ers = 1; busy = 40;
            end
         1: st = (d == 8'h55) ? 2 : 0;
         2: begin
            st = (d == 8'h90) ? 3 : (d == 8'ha0) ? 4 : (d == 8'h80) ? 5 : 0;
            if (d == 8'h20) byp = 1;
         end
         // protection waived only under elevated reset
         4: begin
            if (!(al[21:16] == PROT && !pins.hv_rst))
               mem[{al[16], al[3:0]}] &= d;
            st = 0; busy = 6;
         end
         5: st = (d == 8'haa) ? 6 : 0;
         6: st = (d == 8'h55) ? 7 : 0;
         7: begin
            if (d == 8'h10 || d == 8'h30) busy = 60;
            // Erase wipes its part of the slice at once, A16 picks half
            for (int i = 0; i < 32; i++) begin
               if (d == 8'h10 || (d == 8'h30 && i[4] == al[16]))
                  mem[i] = 8'hff;
            end
            ers = (d == 8'h30); st = 0;
         end
         default: st = 0;
      endcase
   end
endmodule // fcs_flash_model

/* tb.sv */
// Self-checking bench for the flash command sequencer.
// Assumes the flash model on the pins; one request at a time.
`timescale 1ns/1ps

module tb;
   import fcs_pkg::*;
   logic mclk = 0, srst = 1, cmd_valid = 0, tu = 0, sl = 0;
   fcs_cmd_type cmd = '0;
   fcs_rsp_type rsp, r;
   fcs_pins_type pins;
   fcs_erase_type es;
   logic cmd_ready, rsp_valid, flash_ready, in_bypass;
   logic [7:0] dq_i;
   int num_errors = 0, n_checks = 0, w;
   fcs_sequencer i_dut (.mclk(mclk), .srst(srst), .cmd(cmd),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp(rsp),
      .rsp_valid(rsp_valid), .temp_unprotect(tu), .supply_low(sl),
      .flash_ready(flash_ready), .dq_i(dq_i), .pins(pins),
      .in_bypass(in_bypass), .erase_state(es));
   fcs_flash_model i_mdl (.mclk(mclk), .pins(pins), .dq_i(dq_i),
      .flash_ready(flash_ready));
   initial forever #12.5 mclk = ~mclk;
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One request, held until taken, then its answer
   task automatic op(input fcs_op_type o, input logic [21:0] a,
      input logic [7:0] d);
      int n;
      @(posedge mclk);
      cmd <= '{o, a, d};
      cmd_valid <= 1'b1;
      n = 0;
      do begin @(negedge mclk); n++; end while (cmd_ready !== 1'b1 && n < 300);
      @(posedge mclk);
      cmd_valid <= 1'b0;
      do begin @(negedge mclk); n++; end while (rsp_valid !== 1'b1 && n < 400);
      r = rsp;
      check(n < 400, 1'b1);
   endtask
   task automatic t_prog;
      w = i_mdl.nwr;
      op(OP_PROGRAM, 22'h000003, 8'h5a);
      check(i_mdl.nwr - w, 4);
      op(OP_READ, 22'h000003, 8'h00);
      check(r.data, 8'h5a);
   endtask
   task automatic t_ident;
      op(OP_ID_READ, 22'h000000, 8'h00);
      check(r.data, 8'h3c);
      op(OP_ID_READ, 22'h000001, 8'h00);
      check(r.data, 8'h5e);
      op(OP_PROT_VERIFY, 22'h050000, 8'h00);
      check(r.data, 8'h01);
      check(i_mdl.st, 0);
      op(OP_HW_ID, 22'h000001, 8'h00);
      check(r.data, 8'h5e);
      op(OP_HW_ID, 22'h000000, 8'h00);
      check(r.data, 8'h3c);
      op(OP_HW_VERIFY, 22'h050000, 8'h00);
      check(r.data, 8'h01);
      op(OP_HW_VERIFY, 22'h000000, 8'h00);
      check(r.data, 8'h00);
   endtask
   task automatic t_bypass;
      op(OP_BYPASS_ENTER, 22'h0, 8'h00);
      check(in_bypass, 1'b1);
      op(OP_PROGRAM, 22'h000004, 8'h11);
      check(r.err, 1'b1);
      op(OP_BYPASS_PROG, 22'h000004, 8'h3c);
      op(OP_BYPASS_EXIT, 22'h0, 8'h00);
      check(in_bypass, 1'b0);
      check(i_mdl.byp, 1'b0);
      op(OP_READ, 22'h000004, 8'h00);
      check(r.data, 8'h3c);
   endtask
   task automatic t_erase;
      op(OP_SUSPEND, 22'h0, 8'h00);
      check(r.err, 1'b1);
      op(OP_RESUME, 22'h0, 8'h00);
      check(r.err, 1'b1);
      w = i_mdl.nwr;
      op(OP_CHIP_ERASE, 22'h0, 8'h00);
      check(i_mdl.nwr - w, 6);
      op(OP_READ, 22'h000003, 8'h00);
      check(r.data, 8'hff);
      op(OP_SECTOR_ERASE, 22'h010000, 8'h00);
      check(es, ER_ERASING);
      op(OP_SUSPEND, 22'h0, 8'h00);
      check(es, ER_SUSPENDED);
      op(OP_PROGRAM, 22'h000003, 8'h5a);
      op(OP_READ, 22'h000003, 8'h00);
      check(r.data, 8'h5a);
      op(OP_RESUME, 22'h0, 8'h00);
      check(es, ER_ERASING);
      repeat (120) @(negedge mclk);
      check(es, ER_NONE);
   endtask
   task automatic t_unprot;
      op(OP_PROGRAM, 22'h050001, 8'h00);
      op(OP_READ, 22'h050001, 8'h00);
      check(r.data, 8'hff);
      @(posedge mclk) tu <= 1'b1;
      repeat (3) @(negedge mclk);
      check(pins.hv_rst, 1'b1);
      op(OP_PROGRAM, 22'h050001, 8'h00);
      op(OP_READ, 22'h050001, 8'h00);
      check(r.data, 8'h00);
      @(posedge mclk) tu <= 1'b0;
      repeat (3) @(negedge mclk);
      check(pins.hv_rst, 1'b0);
      op(OP_PROGRAM, 22'h050002, 8'h00);
      op(OP_READ, 22'h050002, 8'h00);
      check(r.data, 8'hff);
   endtask
   task automatic t_supply;
      @(posedge mclk) sl <= 1'b1;
      @(negedge mclk);
      check(cmd_ready, 1'b0);
      @(posedge mclk) sl <= 1'b0;
      op(OP_RESET, 22'h0, 8'h00);
      check(r.err, 1'b0);
      op(OP_BYPASS_ENTER, 22'h0, 8'h00);
      op(OP_HW_RESET, 22'h0, 8'h00);
      check(in_bypass, 1'b0);
      check(i_mdl.byp, 1'b0);
      check(pins.rst_n, 1'b1);
   endtask
   initial begin
      #(25 * 20000);
      num_errors++;
      finish_test;
   end
   initial begin
      repeat (2) @(posedge mclk);
      check(pins.rst_n, 1'b0);
      srst <= 1'b0;
      repeat (2) @(negedge mclk);
      check(pins.rst_n, 1'b1);
      t_prog;
      t_ident;
      t_bypass;
      t_erase;
      t_unprot;
      t_supply;
      finish_test;
   end
endmodule // tb
